// ---- uip_cfg.svh ----
// offsets, field positions, codes and reset values of the interrupt priority block
`ifndef UIP_CFG_SVH
`define UIP_CFG_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define UIP_OFF_ISR 8'h00
`define UIP_OFF_FCR 8'h04
`define UIP_OFF_EFR 8'h08
`define UIP_OFF_EVT 8'h0C
`define UIP_OFF_MSK 8'h10

// ------------------------------------------------------------
// field positions and widths
// ------------------------------------------------------------
`define UIP_FCR_FIFOEN 0
`define UIP_EFR_ENH 4
`define UIP_NSRC 8

// ------------------------------------------------------------
// status codes, bits 5..0
// ------------------------------------------------------------
`define UIP_CODE_LINE 6'h06
`define UIP_CODE_RXD 6'h04
`define UIP_CODE_RXTO 6'h0C
`define UIP_CODE_TXE 6'h02
`define UIP_CODE_MODEM 6'h00
`define UIP_CODE_XOFF 6'h10
`define UIP_CODE_FLOW 6'h20
`define UIP_CODE_NONE 6'h01

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define UIP_ISR_RST 8'h01
`define UIP_VEC_RST 8'h00

`endif

// ---- uip_pkg.sv ----
// types shared by the interrupt priority block
`default_nettype none
package uip_pkg;

	// pending source slots, lower index is more urgent
	typedef enum logic [2:0] {
		UIP_SRC_LINE = 3'h0,
		UIP_SRC_RXD = 3'h1,
		UIP_SRC_RXTO = 3'h2,
		UIP_SRC_TXE = 3'h3,
		UIP_SRC_MODEM = 3'h4,
		UIP_SRC_XOFF = 3'h5,
		UIP_SRC_SPEC = 3'h6,
		UIP_SRC_FLOW = 3'h7
	} uip_src_t;

	typedef logic [7:0] uip_vec_t;

endpackage : uip_pkg
`default_nettype wire

// ---- uip_prio_if.sv ----
// carrier between the register file and the priority encoder
`timescale 1ns/1ps
`default_nettype none
interface uip_prio_if;
	uip_pkg::uip_vec_t pend;
	logic featEn;
	logic [5:0] code;
	uip_pkg::uip_vec_t clrSel;

	modport regs (output pend, output featEn, input code, input clrSel);
	modport enc (input pend, input featEn, output code, output clrSel);
endinterface : uip_prio_if
`default_nettype wire

// ---- uip_prio_enc.sv ----
// ranks pending sources and produces the status code
`timescale 1ns/1ps
`default_nettype none
`include "uip_cfg.svh"
module uip_prio_enc (
	uip_prio_if.enc p
);

	function automatic logic [5:0] codeOf(input uip_pkg::uip_src_t s);
		logic [5:0] c;
		c = `UIP_CODE_NONE;
		unique case (s)
			uip_pkg::UIP_SRC_LINE: c = `UIP_CODE_LINE;
			uip_pkg::UIP_SRC_RXD: c = `UIP_CODE_RXD;
			uip_pkg::UIP_SRC_RXTO: c = `UIP_CODE_RXTO;
			uip_pkg::UIP_SRC_TXE: c = `UIP_CODE_TXE;
			uip_pkg::UIP_SRC_MODEM: c = `UIP_CODE_MODEM;
			uip_pkg::UIP_SRC_XOFF: c = `UIP_CODE_XOFF;
			uip_pkg::UIP_SRC_SPEC: c = `UIP_CODE_XOFF;
			uip_pkg::UIP_SRC_FLOW: c = `UIP_CODE_FLOW;
		endcase
		return c;
	endfunction : codeOf

	uip_pkg::uip_vec_t gated;

	always_comb begin
		gated = p.pend;
		// levels 5 to 7 exist only with enhanced features on
		if (!p.featEn) begin
			gated[7:5] = 3'h0;
		end
		p.code = `UIP_CODE_NONE;
		p.clrSel = `UIP_VEC_RST;
		// walk from least to most urgent so the most urgent wins
		for (int i = 7; i >= 0; i--) begin
			if (gated[i]) begin
				p.code = codeOf(uip_pkg::uip_src_t'(3'(i)));
				p.clrSel = `UIP_VEC_RST;
				p.clrSel[i] = 1'b1;
			end
		end
	end

endmodule : uip_prio_enc
`default_nettype wire

// ---- uart_int_prio.sv ----
// interrupt priority and status register of one uart channel, apb slave
`timescale 1ns/1ps
`default_nettype none
`include "uip_cfg.svh"
module uart_int_prio (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// source events, one-cycle pulses
	input wire logic lineEvt,
	input wire logic rxReadyEvt,
	input wire logic rxTimeoutEvt,
	input wire logic txEmptyEvt,
	input wire logic modemEvt,
	input wire logic xoffEvt,
	input wire logic xonEvt,
	input wire logic specialEvt,
	input wire logic flowEvt,
	// interrupt
	output logic irq
);

	// assertions below all run on clk and, except isr_reset_a, stand down during reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// encoder
	// ------------------------------------------------------------
	uip_prio_if prio ();

	uip_prio_enc u_enc (
		.p(prio.enc)
	);

	uip_pkg::uip_vec_t pend_ff;
	logic fifoEn_ff;
	logic enhEn_ff;
	uip_pkg::uip_vec_t evtVec;

	assign prio.pend = pend_ff;
	assign prio.featEn = enhEn_ff;

	always_comb begin
		evtVec = `UIP_VEC_RST;
		evtVec[uip_pkg::UIP_SRC_LINE] = lineEvt;
		evtVec[uip_pkg::UIP_SRC_RXD] = rxReadyEvt;
		evtVec[uip_pkg::UIP_SRC_RXTO] = rxTimeoutEvt;
		evtVec[uip_pkg::UIP_SRC_TXE] = txEmptyEvt;
		evtVec[uip_pkg::UIP_SRC_MODEM] = modemEvt;
		evtVec[uip_pkg::UIP_SRC_XOFF] = xoffEvt;
		evtVec[uip_pkg::UIP_SRC_SPEC] = specialEvt;
		evtVec[uip_pkg::UIP_SRC_FLOW] = flowEvt;
	end

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic setup;
	logic done;
	logic wrDone;
	logic hitIsr;
	logic mapped;

	assign setup = psel && !penable;
	assign done = psel && penable && pready;
	assign wrDone = done && pwrite;
	assign hitIsr = (paddr == `UIP_OFF_ISR);
	assign mapped = hitIsr || (paddr == `UIP_OFF_FCR) || (paddr == `UIP_OFF_EFR)
		|| (paddr == `UIP_OFF_EVT) || (paddr == `UIP_OFF_MSK);

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			fifoEn_ff <= 1'b0;
		end else if (wrDone && paddr == `UIP_OFF_FCR) begin
			fifoEn_ff <= pwdata[`UIP_FCR_FIFOEN];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			enhEn_ff <= 1'b0;
		end else if (wrDone && paddr == `UIP_OFF_EFR) begin
			enhEn_ff <= pwdata[`UIP_EFR_ENH];
		end
	end

	// ------------------------------------------------------------
	// pending set and read-to-clear
	// ------------------------------------------------------------
	uip_pkg::uip_vec_t clrLatch_ff;
	uip_pkg::uip_vec_t readClr;
	logic isrRdDone;

	assign isrRdDone = done && !pwrite && hitIsr;

	// the slot to clear is caught with the returned data, so a source
	// arriving during the access is never cleared unseen
	always_ff @(posedge clk) begin
		if (rst) begin
			clrLatch_ff <= `UIP_VEC_RST;
		end else if (setup && hitIsr && !pwrite) begin
			clrLatch_ff <= prio.clrSel;
		end
	end

	always_comb begin
		readClr = isrRdDone ? clrLatch_ff : `UIP_VEC_RST;
		// xoff is only ever cleared by the matching xon
		readClr[uip_pkg::UIP_SRC_XOFF] = xonEvt;
	end

	// a new event in the clearing cycle keeps its slot pending
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_ff <= `UIP_VEC_RST;
		end else begin
			pend_ff <= (pend_ff & ~readClr) | evtVec;
		end
	end

	// ------------------------------------------------------------
	// event status, mask and interrupt line
	// ------------------------------------------------------------
	uip_pkg::uip_vec_t evtStat_ff;
	uip_pkg::uip_vec_t mask_ff;
	uip_pkg::uip_vec_t w1c;

	assign w1c = (wrDone && paddr == `UIP_OFF_EVT) ? pwdata[7:0] : `UIP_VEC_RST;

	always_ff @(posedge clk) begin
		if (rst) begin
			evtStat_ff <= `UIP_VEC_RST;
		end else begin
			evtStat_ff <= (evtStat_ff & ~w1c) | evtVec;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mask_ff <= `UIP_VEC_RST;
		end else if (wrDone && paddr == `UIP_OFF_MSK) begin
			mask_ff <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evtStat_ff & mask_ff);
		end
	end

	// ------------------------------------------------------------
	// read data and handshake
	// ------------------------------------------------------------
	logic [7:0] isrView;
	logic [7:0] rdMux;

	// upper pair mirrors fifo enable, low six bits are the live code
	assign isrView = {fifoEn_ff, fifoEn_ff, prio.code};

	always_comb begin
		rdMux = 8'h00;
		unique case (paddr)
			`UIP_OFF_ISR: rdMux = isrView;
			`UIP_OFF_FCR: rdMux = {7'h00, fifoEn_ff};
			`UIP_OFF_EFR: rdMux = {3'h0, enhEn_ff, 4'h0};
			`UIP_OFF_EVT: rdMux = evtStat_ff;
			`UIP_OFF_MSK: rdMux = mask_ff;
			default: rdMux = 8'h00;
		endcase
	end

	// data is frozen at setup so the access returns what was ranked then
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= (pwrite || !mapped) ? 32'h00000000 : {24'h000000, rdMux};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup && !mapped;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic anyHigh;
	assign anyHigh = |pend_ff[2:0];

	isr_reset_a: assert property (disable iff (1'b0) rst |=> isrView == `UIP_ISR_RST)
		else $error("status not idle after reset");

	line_first_a: assert property (pend_ff[0] |-> prio.code == `UIP_CODE_LINE)
		else $error("line status not reported first");

	rx_ready_a: assert property (!pend_ff[0] && pend_ff[1] |-> prio.code == `UIP_CODE_RXD)
		else $error("rx ready code wrong");

	rx_timeout_a: assert property (pend_ff[2:0] == 3'h4 |-> prio.code == `UIP_CODE_RXTO)
		else $error("rx timeout code wrong");

	tx_empty_a: assert property (!anyHigh && pend_ff[3] |-> prio.code == `UIP_CODE_TXE)
		else $error("tx empty code wrong");

	modem_code_a: assert property (pend_ff[4:0] == 5'h10 |-> prio.code == `UIP_CODE_MODEM)
		else $error("modem code wrong");

	idle_code_a: assert property (pend_ff == 8'h00 |-> prio.code[0])
		else $error("pending flagged with nothing pending");

	xoff_code_a: assert property (enhEn_ff && pend_ff[6:0] == 7'h20 |-> prio.code == `UIP_CODE_XOFF)
		else $error("xoff code wrong");

	flow_code_a: assert property (enhEn_ff && pend_ff == 8'h80 |-> prio.code == `UIP_CODE_FLOW)
		else $error("flow change code wrong");

	feat_gate_a: assert property (!enhEn_ff |-> prio.code[5:4] == 2'h0)
		else $error("enhanced bits reported while disabled");

	xoff_hold_a: assert property (pend_ff[5] && !xonEvt |=> pend_ff[5])
		else $error("xoff flag dropped without xon");

	fifo_bits_a: assert property (setup && hitIsr && !pwrite |=> prdata[7:6] == {2{$past(fifoEn_ff)}})
		else $error("fifo bits wrong in status");

	fcr_follow_a: assert property (wrDone && paddr == `UIP_OFF_FCR |=> fifoEn_ff == $past(pwdata[0]))
		else $error("fifo enable did not follow write");

	read_value_a: assert property (setup && hitIsr && !pwrite |=> prdata[5:0] == $past(prio.code))
		else $error("read returned wrong code");

	live_code_a: assert property ($changed(pend_ff) && pend_ff[0] |-> prio.code == `UIP_CODE_LINE)
		else $error("code not recomputed");

	read_clear_a: assert property (isrRdDone && clrLatch_ff[1] && !rxReadyEvt |=> !pend_ff[1])
		else $error("reported interrupt not cleared");

	keep_lower_a: assert property (isrRdDone && pend_ff[3] && !clrLatch_ff[3] |=> pend_ff[3])
		else $error("unreported interrupt cleared");

	hold_line_a: assert property (pend_ff[0] && !isrRdDone |=> prio.code == `UIP_CODE_LINE)
		else $error("pending interrupt displaced");

	rank_order_a: assert property (pend_ff[0] && pend_ff[3] |-> prio.clrSel == 8'h01)
		else $error("simultaneous requests misranked");

	irq_level_a: assert property (|(evtStat_ff & mask_ff) |=> irq)
		else $error("interrupt line missing");

	special_code_a: assert property (enhEn_ff && pend_ff[6:0] == 7'h40 |-> prio.code == `UIP_CODE_XOFF)
		else $error("special character code wrong");

	code_pending_a: assert property (|pend_ff[4:0] |-> !prio.code[0])
		else $error("pending source shown as idle");

	gate_hide_a: assert property (!enhEn_ff && pend_ff[4:0] == 5'h00 |-> prio.code == `UIP_CODE_NONE)
		else $error("hidden source reported");

	fifo_track_a: assert property (wrDone && paddr == `UIP_OFF_FCR
		|=> isrView[7:6] == {2{$past(pwdata[`UIP_FCR_FIFOEN])}})
		else $error("fifo bits did not follow control write");

	idle_view_a: assert property (pend_ff == 8'h00 && !fifoEn_ff |-> isrView == `UIP_ISR_RST)
		else $error("idle status value wrong");

	line_clear_a: assert property (isrRdDone && clrLatch_ff[0] && !lineEvt |=> !pend_ff[0])
		else $error("line status not cleared by read");

	xon_clear_a: assert property (xonEvt && !xoffEvt |=> !pend_ff[5])
		else $error("xoff flag not cleared by xon");

	evt_kept_a: assert property (|evtVec |=> (~pend_ff & $past(evtVec)) == 8'h00)
		else $error("new event lost");

	clr_single_a: assert property ($onehot0(prio.clrSel))
		else $error("more than one slot selected for clearing");

	// bus handshake: one zero-wait answer per setup
	ready_setup_a: assert property (setup |=> pready)
		else $error("no ready after setup");

	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");

	unmapped_err_a: assert property (setup && !mapped |=> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");

	prdata_hold_a: assert property (!setup |=> $stable(prdata))
		else $error("read data changed outside setup");

	two_reads_c: cover property (isrRdDone && pend_ff[0] && pend_ff[3] ##[1:20] isrRdDone);
	xoff_xon_c: cover property (pend_ff[5] && enhEn_ff ##[1:50] xonEvt);
	unmapped_c: cover property (setup && !mapped);
	irq_c: cover property ($rose(irq));
	gated_flow_c: cover property (!enhEn_ff && pend_ff[7]);

endmodule : uart_int_prio
`default_nettype wire

// ---- uip_host.sv ----
// apb host model that reads and writes the block's registers
`timescale 1ns/1ps
`default_nettype none
module uip_host (
	// clock
	input wire logic clk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ------------------------------------------------------------
	// idle bus
	// ------------------------------------------------------------
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'hFF;
		pwdata = 32'hFFFFFFFF;
	end

	// ------------------------------------------------------------
	// one transfer, entered just after a rising edge
	// ------------------------------------------------------------
	// address and data are inverted on release so a stale value never looks valid
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		paddr <= ~a;
		pwdata <= ~wd;
		@(posedge clk);
	endtask : xfer
endmodule : uip_host
`default_nettype wire

// ---- test_uart_interrupt_priority_status.sv ----
// self-checking bench for the uart interrupt priority block
`timescale 1ns/1ps
`default_nettype none
`include "uip_cfg.svh"
module test_uart_interrupt_priority_status;
	logic clk;
	logic rst;
	logic psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	// event bits: line, rx ready, rx timeout, tx empty, modem, xoff, special, flow, xon
	logic [8:0] evt;
	int numErrors;
	int testsRun;

	always #10 clk = ~clk;

	uart_int_prio i_uart_int_prio (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lineEvt(evt[0]), .rxReadyEvt(evt[1]), .rxTimeoutEvt(evt[2]),
		.txEmptyEvt(evt[3]), .modemEvt(evt[4]), .xoffEvt(evt[5]), .specialEvt(evt[6]),
		.flowEvt(evt[7]), .xonEvt(evt[8]), .irq(irq));

	uip_host i_uip_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		i_uip_host.xfer(1'h1, a, d, r, e);
		chk("write error flag", 32'h0, {31'h0, e});
	endtask : wr

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		i_uip_host.xfer(1'h0, a, 32'h0, r, e);
		chk(what, exp, r);
	endtask : rdchk

	// one-cycle event pulse, then time for the code to settle
	task automatic fire(input logic [8:0] v);
		evt <= v;
		@(posedge clk);
		evt <= 9'h0;
		@(posedge clk);
		@(posedge clk);
	endtask : fire

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset;
		logic [31:0] r;
		logic e;
		rdchk("status after reset", `UIP_OFF_ISR, 32'h01);
		chk("irq after reset", 32'h0, {31'h0, irq});
		i_uip_host.xfer(1'h0, 8'h14, 32'h0, r, e);
		chk("unmapped error flag", 32'h1, {31'h0, e});
		chk("unmapped read data", 32'h0, r);
	endtask : test_reset

	// all sources but xoff at once; seven reads report and clear one level each, the eighth sees idle
	task automatic test_priority;
		wr(`UIP_OFF_EFR, 32'h10);
		fire(9'h0DF);
		rdchk("line", `UIP_OFF_ISR, {26'h0, `UIP_CODE_LINE});
		rdchk("rx ready", `UIP_OFF_ISR, {26'h0, `UIP_CODE_RXD});
		rdchk("rx timeout", `UIP_OFF_ISR, {26'h0, `UIP_CODE_RXTO});
		rdchk("tx empty", `UIP_OFF_ISR, {26'h0, `UIP_CODE_TXE});
		rdchk("modem", `UIP_OFF_ISR, {26'h0, `UIP_CODE_MODEM});
		rdchk("special char", `UIP_OFF_ISR, {26'h0, `UIP_CODE_XOFF});
		rdchk("flow change", `UIP_OFF_ISR, {26'h0, `UIP_CODE_FLOW});
		rdchk("drained", `UIP_OFF_ISR, {26'h0, `UIP_CODE_NONE});
	endtask : test_priority

	task automatic test_xoff;
		fire(9'h020);
		rdchk("xoff status", `UIP_OFF_ISR, 32'h10);
		rdchk("xoff status held", `UIP_OFF_ISR, 32'h10);
		fire(9'h100);
		rdchk("status after xon", `UIP_OFF_ISR, 32'h01);
	endtask : test_xoff

	task automatic test_gate;
		wr(`UIP_OFF_EFR, 32'h0);
		fire(9'h080);
		rdchk("flow change hidden", `UIP_OFF_ISR, 32'h01);
		wr(`UIP_OFF_EFR, 32'h10);
		rdchk("flow change shown", `UIP_OFF_ISR, 32'h20);
		rdchk("status drained", `UIP_OFF_ISR, 32'h01);
	endtask : test_gate

	task automatic test_fifo;
		wr(`UIP_OFF_FCR, 32'h1);
		rdchk("fifo bits idle", `UIP_OFF_ISR, 32'hC1);
		fire(9'h008);
		rdchk("fifo bits with tx empty", `UIP_OFF_ISR, 32'hC2);
		wr(`UIP_OFF_FCR, 32'h0);
		rdchk("fifo bits off", `UIP_OFF_ISR, 32'h01);
	endtask : test_fifo

	task automatic test_irq;
		wr(`UIP_OFF_EVT, 32'hFF);
		wr(`UIP_OFF_MSK, 32'h0);
		fire(9'h008);
		chk("irq while masked", 32'h0, {31'h0, irq});
		rdchk("event status", `UIP_OFF_EVT, 32'h08);
		wr(`UIP_OFF_MSK, 32'h08);
		repeat (3) @(posedge clk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(`UIP_OFF_EVT, 32'h08);
		repeat (3) @(posedge clk);
		chk("irq after clear", 32'h0, {31'h0, irq});
		rdchk("event cleared", `UIP_OFF_EVT, 32'h0);
		rdchk("tx empty still pending", `UIP_OFF_ISR, 32'h02);
	endtask : test_irq

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d errors %0d", testsRun, numErrors);
		if (numErrors == 0 && testsRun > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	initial begin
		clk = 1'h0;
		rst = 1'h1;
		evt = 9'h0;
		numErrors = 0;
		testsRun = 0;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		test_reset();
		test_priority();
		test_xoff();
		test_gate();
		test_fifo();
		test_irq();
		give_verdict();
	end

	// the whole run needs about 120 cycles; this leaves ample margin
	initial begin
		repeat (5000) @(posedge clk);
		numErrors++;
		give_verdict();
	end
endmodule : test_uart_interrupt_priority_status
`default_nettype wire
